// File: include/tprc_map.vh
// Register offsets, field positions, reset values and timing counts for the
// thermopile result and configuration block. Definitions only.
`ifndef TPRC_MAP_VH
`define TPRC_MAP_VH

`define TPRC_ADDR_VOLT 8'h00
`define TPRC_ADDR_DIE 8'h01
`define TPRC_ADDR_CFG 8'h02
`define TPRC_ADDR_OBJ 8'h03
`define TPRC_ADDR_STAT 8'h04
`define TPRC_ADDR_MASK 8'h05

`define TPRC_CFG_RESET 16'h1440
`define TPRC_MASK_RESET 16'h0000
`define TPRC_RES_RESET 16'h0000

`define TPRC_CFG_RST_BIT 15
`define TPRC_CFG_RUN_BIT 12
`define TPRC_CFG_RATE_HI 11
`define TPRC_CFG_RATE_LO 9
`define TPRC_CFG_IRQEN_BIT 8
`define TPRC_CFG_SUM_BIT 7
`define TPRC_CFG_TF_BIT 6
`define TPRC_CFG_CMP_BIT 5

`define TPRC_MASK_IRQEN_BIT 15
`define TPRC_MASK_HI 14
`define TPRC_MASK_LO 8

`define TPRC_ST_SUM 15
`define TPRC_ST_DONE 14
`define TPRC_ST_OBJ_HI 13
`define TPRC_ST_OBJ_LO 12
`define TPRC_ST_DIE_HI 11
`define TPRC_ST_DIE_LO 10
`define TPRC_ST_INVALID 9
`define TPRC_ST_MEM 8
`define TPRC_ST_OVF 7

// Conversion slot 0.25 s, idle per rate code; counts in 4 ns cycles
`define TPRC_CLK_MHZ 250
`define TPRC_SLOT_MS 250
`define TPRC_SLOT_CYC (`TPRC_SLOT_MS * 1000 * `TPRC_CLK_MHZ)
`define TPRC_IDLE5_MS 750
`define TPRC_IDLE6_MS 3500
`define TPRC_IDLE7_MS 3000
`define TPRC_IDLE5_CYC (`TPRC_IDLE5_MS * 1000 * `TPRC_CLK_MHZ)
`define TPRC_IDLE6_CYC (`TPRC_IDLE6_MS * 1000 * `TPRC_CLK_MHZ)
`define TPRC_IDLE7_CYC (`TPRC_IDLE7_MS * 1000 * `TPRC_CLK_MHZ)

`endif

// File: rtl/tprc_core.v
// Result, configuration, status and mask registers of a thermopile sensor.
// Assumes the serial bus front end gives one-cycle rd/wr strobes with an address,
// and that the math engine delivers results with a one-cycle result strobe.
//
// Overview of operation
// - Voltage result is a 16-bit two's complement word, 156.25 nV per LSB.
// - Die temperature sits in bits 15:2, bits 1:0 read zero.
// - Object temperature sits in bits 15:2, 0.03125 degC per LSB.
// - Object bit 0 marks invalid math, cleared by next valid conversion.
// - Configuration write restarts conversion unless it powers down.
// - Writing 1 to bit 15 resets everything, conversion restarts a cycle later at reset defaults, bit self-clears.
// - Bit 12 selects power down (0) or running (1), default 1.
// - Bits 11:9 codes 0-4 average 1 to 16 conversions.
// - Codes 5-7 average 1, 2, 4 then idle 0.75, 3.5, 3.0 s.
// - Bit 8 lets the summary flag drive the active-low alert.
// - Alert enable is one bit seen in configuration and mask registers.
// - Config bit 7 is OR of enabled flags, mirrors status bit 15.
// - Bit 6 enables transient filtering of voltage and object outputs.
// - Bit 5 selects latched (0) or comparator (1) behaviour of the limit and invalid flags.
// - Latched flags set on violation, clear only on status read.
// - Latched flag stays set when next conversion is clean.
// - Comparator flags follow each conversion's violation result.
// - Status bits 15 down to 7 hold the named flags.
// - Each mask bit gates its status flag into the summary flag.
// - Done flag sets after conversions, clears on status read, config write or result read.
`timescale 1ns/1ps
`include "tprc_map.vh"
module tprc_core #(
	parameter SLOT_CYC = `TPRC_SLOT_CYC,
	parameter IDLE5_CYC = `TPRC_IDLE5_CYC,
	parameter IDLE6_CYC = `TPRC_IDLE6_CYC,
	parameter IDLE7_CYC = `TPRC_IDLE7_CYC
) (
	input wire clk_sys,
	input wire rstn,
	input wire [7:0] reg_addr,
	input wire reg_wr,
	input wire [15:0] reg_wdata,
	input wire reg_rd,
	output reg [15:0] reg_rdata,
	input wire sample_valid,
	input wire [15:0] thermopile_voltage,
	input wire [13:0] die_temperature,
	input wire [13:0] object_temperature,
	input wire math_invalid,
	input wire voltage_overrange,
	input wire obj_high_viol,
	input wire obj_low_viol,
	input wire die_high_viol,
	input wire die_low_viol,
	input wire memory_corrupt,
	output wire conv_active,
	output wire conv_restart,
	output wire transient_filter_en,
	output wire alert_n
);
	localparam ST_OFF = 2'd0;
	localparam ST_CONV = 2'd1;
	localparam ST_IDLE = 2'd2;
	localparam [15:0] CFG_RST = `TPRC_CFG_RESET;
	localparam [15:0] MASK_RST = `TPRC_MASK_RESET;
	localparam [15:0] RES_RST = `TPRC_RES_RESET;

	reg [15:0] volt_reg;
	reg [13:0] die_reg;
	reg [13:0] obj_reg;
	reg object_invalid_bit;
	reg run_select;
	reg [2:0] rate_sel;
	reg irq_output_enable;
	reg transient_en_reg;
	reg compare_mode;
	reg [6:0] mask_reg;
	reg conversion_done_flag;
	reg memory_corrupt_flag;
	reg voltage_overflow_flag;
	reg [1:0] state_reg;
	reg [1:0] state_next;
	reg [31:0] cnt_reg;
	reg [31:0] cnt_next;
	reg [4:0] slot_reg;
	reg [4:0] slot_next;
	reg conv_end;
	reg [4:0] slots_needed;
	reg [31:0] idle_cycles;
	wire [15:0] status_word;

	wire wr_cfg = reg_wr && (reg_addr == `TPRC_ADDR_CFG);
	wire wr_mask = reg_wr && (reg_addr == `TPRC_ADDR_MASK);
	wire sw_reset = wr_cfg && reg_wdata[`TPRC_CFG_RST_BIT];
	wire rd_stat = reg_rd && (reg_addr == `TPRC_ADDR_STAT);
	wire rd_result = reg_rd && ((reg_addr == `TPRC_ADDR_VOLT) ||
		(reg_addr == `TPRC_ADDR_DIE) || (reg_addr == `TPRC_ADDR_OBJ));
	// Power-down acts on the write edge, so no slot finishes after it
	wire pd_write = wr_cfg && !reg_wdata[`TPRC_CFG_RUN_BIT];
	// Restart only when the write leaves the device running
	assign conv_restart = wr_cfg && !sw_reset && reg_wdata[`TPRC_CFG_RUN_BIT];
	assign conv_active = (state_reg == ST_CONV);
	assign transient_filter_en = transient_en_reg;

	wire obj_hi_f, obj_lo_f, die_hi_f, die_lo_f, inval_f;
	tprc_limit_flag u_obj_hi (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.sw_reset(sw_reset),
		.compare_mode(compare_mode),
		.conv_end(conv_end),
		.violated(obj_high_viol),
		.status_read(rd_stat),
		.flag(obj_hi_f)
	);
	tprc_limit_flag u_obj_lo (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.sw_reset(sw_reset),
		.compare_mode(compare_mode),
		.conv_end(conv_end),
		.violated(obj_low_viol),
		.status_read(rd_stat),
		.flag(obj_lo_f)
	);
	tprc_limit_flag u_die_hi (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.sw_reset(sw_reset),
		.compare_mode(compare_mode),
		.conv_end(conv_end),
		.violated(die_high_viol),
		.status_read(rd_stat),
		.flag(die_hi_f)
	);
	tprc_limit_flag u_die_lo (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.sw_reset(sw_reset),
		.compare_mode(compare_mode),
		.conv_end(conv_end),
		.violated(die_low_viol),
		.status_read(rd_stat),
		.flag(die_lo_f)
	);
	tprc_limit_flag u_inval (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.sw_reset(sw_reset),
		.compare_mode(compare_mode),
		.conv_end(conv_end),
		.violated(math_invalid || voltage_overrange),
		.status_read(rd_stat),
		.flag(inval_f)
	);

	// Combinational OR so bit 7 and status bit 15 can never disagree
	wire summary_flag = |({conversion_done_flag, obj_hi_f, obj_lo_f, die_hi_f, die_lo_f,
		inval_f, memory_corrupt_flag} & mask_reg);
	assign status_word = {summary_flag, conversion_done_flag, obj_hi_f, obj_lo_f,
		die_hi_f, die_lo_f, inval_f, memory_corrupt_flag, voltage_overflow_flag,
		7'h00};
	assign alert_n = ~(irq_output_enable && summary_flag);

	// Conversion count and idle time per rate code
	always @* begin
		case (rate_sel)
		3'd0: slots_needed = 5'd1;
		3'd1: slots_needed = 5'd2;
		3'd2: slots_needed = 5'd4;
		3'd3: slots_needed = 5'd8;
		3'd4: slots_needed = 5'd16;
		3'd5: slots_needed = 5'd1;
		3'd6: slots_needed = 5'd2;
		default: slots_needed = 5'd4;
		endcase
		case (rate_sel)
		3'd5: idle_cycles = IDLE5_CYC;
		3'd6: idle_cycles = IDLE6_CYC;
		3'd7: idle_cycles = IDLE7_CYC;
		default: idle_cycles = 32'h00000000;
		endcase
	end

	always @* begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		slot_next = slot_reg;
		conv_end = 1'b0;
		case (state_reg)
		ST_OFF: begin
			if (run_select) begin
				state_next = ST_CONV;
				cnt_next = 32'h00000000;
				slot_next = 5'h00;
			end
		end
		ST_CONV: begin
			if (cnt_reg == SLOT_CYC - 1) begin
				cnt_next = 32'h00000000;
				if (slot_reg == slots_needed - 5'd1) begin
					conv_end = 1'b1;
					slot_next = 5'h00;
					if (idle_cycles != 32'h00000000)
						state_next = ST_IDLE;
				end else begin
					slot_next = slot_reg + 5'd1;
				end
			end else begin
				cnt_next = cnt_reg + 32'h00000001;
			end
		end
		ST_IDLE: begin
			if (cnt_reg == idle_cycles - 1) begin
				cnt_next = 32'h00000000;
				state_next = ST_CONV;
			end else begin
				cnt_next = cnt_reg + 32'h00000001;
			end
		end
		default: state_next = ST_OFF;
		endcase
		if (!run_select || pd_write) begin
			state_next = ST_OFF;
			conv_end = 1'b0;
		end
		if (conv_restart) begin
			state_next = ST_CONV;
			cnt_next = 32'h00000000;
			slot_next = 5'h00;
			conv_end = 1'b0;
		end
	end

	always @(posedge clk_sys) begin
		if (!rstn || sw_reset) begin
			state_reg <= ST_OFF;
			cnt_reg <= 32'h00000000;
			slot_reg <= 5'h00;
			run_select <= CFG_RST[`TPRC_CFG_RUN_BIT];
			rate_sel <= CFG_RST[`TPRC_CFG_RATE_HI:`TPRC_CFG_RATE_LO];
			irq_output_enable <= CFG_RST[`TPRC_CFG_IRQEN_BIT];
			transient_en_reg <= CFG_RST[`TPRC_CFG_TF_BIT];
			compare_mode <= CFG_RST[`TPRC_CFG_CMP_BIT];
			mask_reg <= MASK_RST[`TPRC_MASK_HI:`TPRC_MASK_LO];
			volt_reg <= RES_RST;
			die_reg <= RES_RST[15:2];
			obj_reg <= RES_RST[15:2];
			object_invalid_bit <= 1'b0;
			conversion_done_flag <= 1'b0;
			memory_corrupt_flag <= 1'b0;
			voltage_overflow_flag <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			slot_reg <= slot_next;
			if (wr_cfg) begin
				run_select <= reg_wdata[`TPRC_CFG_RUN_BIT];
				rate_sel <= reg_wdata[`TPRC_CFG_RATE_HI:`TPRC_CFG_RATE_LO];
				transient_en_reg <= reg_wdata[`TPRC_CFG_TF_BIT];
				compare_mode <= reg_wdata[`TPRC_CFG_CMP_BIT];
			end
			if (wr_cfg)
				irq_output_enable <= reg_wdata[`TPRC_CFG_IRQEN_BIT];
			else if (wr_mask)
				irq_output_enable <= reg_wdata[`TPRC_MASK_IRQEN_BIT];
			if (wr_mask)
				mask_reg <= reg_wdata[`TPRC_MASK_HI:`TPRC_MASK_LO];
			if (sample_valid) begin
				volt_reg <= thermopile_voltage;
				die_reg <= die_temperature;
				obj_reg <= object_temperature;
			end
			if (conv_end) begin
				object_invalid_bit <= math_invalid;
				voltage_overflow_flag <= voltage_overrange;
				memory_corrupt_flag <= memory_corrupt;
			end
			// Set wins over a same-cycle status or result read; a config write suppresses conv_end
			if (conv_end)
				conversion_done_flag <= 1'b1;
			else if (rd_stat || wr_cfg || rd_result)
				conversion_done_flag <= 1'b0;
		end
	end

	// Read data registered; unmapped addresses return zero
	always @(posedge clk_sys) begin
		if (!rstn)
			reg_rdata <= 16'h0000;
		else if (reg_rd) begin
			if (reg_addr == `TPRC_ADDR_VOLT)
				reg_rdata <= volt_reg;
			else if (reg_addr == `TPRC_ADDR_DIE)
				reg_rdata <= {die_reg, 2'b00};
			else if (reg_addr == `TPRC_ADDR_CFG)
				reg_rdata <= {3'b000, run_select, rate_sel, irq_output_enable,
					summary_flag, transient_en_reg, compare_mode, 5'b00000};
			else if (reg_addr == `TPRC_ADDR_OBJ)
				reg_rdata <= {obj_reg, 1'b0, object_invalid_bit};
			else if (reg_addr == `TPRC_ADDR_STAT)
				reg_rdata <= status_word;
			else if (reg_addr == `TPRC_ADDR_MASK)
				reg_rdata <= {irq_output_enable, mask_reg, 8'h00};
			else
				reg_rdata <= 16'h0000;
		end
	end
endmodule

// File: rtl/tprc_limit_flag.v
// One status flag with latched or comparator behaviour.
// Assumes violation and end-of-conversion come from the same clock.
`timescale 1ns/1ps
module tprc_limit_flag (
	clk_sys,
	rstn,
	sw_reset,
	compare_mode,
	conv_end,
	violated,
	status_read,
	flag
);
	input wire clk_sys;
	input wire rstn;
	input wire sw_reset;
	input wire compare_mode;
	input wire conv_end;
	input wire violated;
	input wire status_read;
	output reg flag;

	reg flag_next;

	always @* begin
		flag_next = flag;
		if (compare_mode) begin
			if (conv_end)
				flag_next = violated;
		end else begin
			// Set wins over a same-cycle status read
			if (status_read)
				flag_next = 1'b0;
			if (conv_end && violated)
				flag_next = 1'b1;
		end
	end

	always @(posedge clk_sys) begin
		if (!rstn || sw_reset)
			flag <= 1'b0;
		else
			flag <= flag_next;
	end
endmodule

// File: verif/tprc_chk.sv
// Port-level assertions for the thermopile register core.
// Assumes it is bound into tprc_core and sees only its ports.
`timescale 1ns/1ps
module tprc_chk (
	input logic clk_sys,
	input logic rstn,
	input logic [7:0] reg_addr,
	input logic reg_wr,
	input logic [15:0] reg_wdata,
	input logic reg_rd,
	input logic [15:0] reg_rdata,
	input logic conv_active,
	input logic conv_restart,
	input logic transient_filter_en,
	input logic alert_n
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	wire cfg_wr = reg_wr && reg_addr == 8'h02;
	wire run_wr = cfg_wr && !reg_wdata[15] && reg_wdata[12];
	wire cfg_set = cfg_wr && !reg_wdata[15];
	wire pd_wr = cfg_set && !reg_wdata[12];
	wire die_rd = reg_rd && reg_addr == 8'h01;
	wire obj_rd = reg_rd && reg_addr == 8'h03;
	wire stat_rd = reg_rd && reg_addr == 8'h04;
	chk_cfg_restart: assert property (run_wr |-> conv_restart)
		else $error("config write did not restart");
	chk_no_stray: assert property (conv_restart |-> run_wr)
		else $error("restart without a running config write");
	chk_pd_stops: assert property (pd_wr |=> !conv_active [*3])
		else $error("conversion runs in power down");
	chk_run_starts: assert property (conv_restart |=> conv_active)
		else $error("restart did not start conversion");
	chk_tf_follow: assert property (cfg_set |=> transient_filter_en == $past(reg_wdata[6]))
		else $error("filter enable not written");
	chk_swrst_out: assert property (cfg_wr && reg_wdata[15] |=> transient_filter_en && alert_n)
		else $error("software reset left outputs");
	chk_die_pad: assert property (die_rd |=> reg_rdata[1:0] == 2'h0)
		else $error("die low bits not zero");
	chk_obj_pad: assert property (obj_rd |=> !reg_rdata[1])
		else $error("object bit 1 not zero");
	chk_stat_unused: assert property (stat_rd |=> reg_rdata[6:0] == 7'h00)
		else $error("status low bits not zero");
	chk_reset_out: assert property ($rose(rstn) |-> alert_n && reg_rdata == 16'h0000)
		else $error("outputs not at reset value");
	cover property (cfg_wr && reg_wdata[15]);
	cover property (cfg_wr && !reg_wdata[12]);
	cover property (!alert_n);
	cover property (cfg_set && reg_wdata[5]);
endmodule

// File: verif/tprc_core_tb.sv
// Self-checking bench for tprc_core with shortened conversion counts.
// Assumes tprc_host and tprc_chk are compiled alongside.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
	$display("BAD %s exp %h got %h", nm, e, g); end end
module tprc_core_tb;
	logic clk_sys = 0;
	logic rstn = 0;
	logic sample_valid = 0, math_invalid = 0, voltage_overrange = 0, memory_corrupt = 0;
	logic obj_high_viol = 0, obj_low_viol = 0, die_high_viol = 0, die_low_viol = 0;
	logic [15:0] thermopile_voltage = 0, r;
	logic [13:0] die_temperature = 0, object_temperature = 0;
	wire [7:0] reg_addr;
	wire [15:0] reg_wdata, reg_rdata;
	wire reg_wr, reg_rd, conv_active, conv_restart, transient_filter_en, alert_n;
	integer seed = 32'hb72f6e07, miscompares = 0, tests_run = 0, i, t;
	always #2 clk_sys = ~clk_sys;
	tprc_core #(.SLOT_CYC(20), .IDLE5_CYC(40), .IDLE6_CYC(60), .IDLE7_CYC(50)) tprc_core_i (.*);
	tprc_host tprc_host_i (.*);
	function automatic integer expc(integer c, integer k);
		expc = 20 * (c < 5 ? 1 << c : 1 << (c - 5));
		expc = expc + k * (c == 5 ? 40 : c == 6 ? 60 : c == 7 ? 50 : 0);
	endfunction
	task cyc(input integer n);
		repeat (n) @(negedge clk_sys);
	endtask
	task rdc(input logic [7:0] a, input logic [15:0] e, input string nm);
		tprc_host_i.rd(a, r);
		`CHK(nm, e, r)
	endtask
	task close_out;
		$display("counts: %0d checks, %0d mismatches", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// Polling clears the done flag, so each call times one conversion end
	task wait_done(output integer n);
		n = 0;
		r = 0;
		while (!r[14] && n < 2000) begin
			tprc_host_i.rd(8'h04, r);
			n = n + 2;
		end
		if (!r[14]) begin
			miscompares++;
			close_out;
		end
	endtask
	initial begin
		cyc(3);
		rstn = 1;
		for (i = 0; i < 7; i++) rdc(i == 6 ? 8'h7F : i[7:0], i == 2 ? 16'h1440 : 16'h0000, "reset");
		`CHK("alert idle", 1'h1, alert_n)
		`CHK("filter on", 1'h1, transient_filter_en)
		tprc_host_i.wr(8'h00, 16'hFFFF);
		rdc(8'h00, 16'h0000, "read only");
		$display("test reset finished");
		for (i = 0; i < 4; i++) begin
			thermopile_voltage = i == 0 ? 16'h8000 : 16'($random(seed));
			{die_temperature, object_temperature} = i == 0 ? 28'h8001FFF : 28'($random(seed));
			sample_valid = 1;
			cyc(1);
			sample_valid = 0;
			rdc(8'h00, thermopile_voltage, "voltage");
			rdc(8'h01, {die_temperature, 2'h0}, "die");
			rdc(8'h03, {object_temperature, 2'h0}, "object");
		end
		$display("test results finished");
		tprc_host_i.wr(8'h05, 16'hA000);
		rdc(8'h02, 16'h1540, "cfg mirror");
		tprc_host_i.wr(8'h02, 16'h1540);
		rdc(8'h05, 16'hA000, "mask");
		obj_high_viol = 1;
		cyc(100);
		`CHK("alert low", 1'h0, alert_n)
		obj_high_viol = 0;
		cyc(90);
		rdc(8'h04, 16'hE000, "latched");
		rdc(8'h04, 16'h0000, "cleared");
		`CHK("alert off", 1'h1, alert_n)
		$display("test latched finished");
		tprc_host_i.wr(8'h02, 16'h1560);
		// Every violation and fault source at once, so each flag position except done is seen set
		{obj_high_viol, obj_low_viol, die_high_viol, die_low_viol} = 4'hF;
		{math_invalid, voltage_overrange, memory_corrupt} = 3'h7;
		cyc(100);
		rdc(8'h02, 16'h15E0, "summary");
		rdc(8'h03, {object_temperature, 2'h1}, "invalid");
		rdc(8'h04, 16'hBF80, "cmp set");
		{obj_high_viol, obj_low_viol, die_high_viol, die_low_viol} = 4'h0;
		{math_invalid, voltage_overrange, memory_corrupt} = 3'h0;
		cyc(80);
		rdc(8'h03, {object_temperature, 2'h0}, "valid");
		rdc(8'h04, 16'h0000, "cmp clear");
		$display("test comparator finished");
		for (i = 0; i < 8; i++) begin
			tprc_host_i.wr(8'h02, {4'h1, i[2:0], 9'h000});
			`CHK("filter off", 1'h0, transient_filter_en)
			wait_done(t);
			`CHK("first end", 1'h1, t >= expc(i, 0) - 2 && t <= expc(i, 0) + 6)
			wait_done(t);
			`CHK("period", 1'h1, t >= expc(i, 1) - 2 && t <= expc(i, 1) + 6)
		end
		$display("test rates finished");
		tprc_host_i.wr(8'h02, 16'h0440);
		cyc(200);
		rdc(8'h04, 16'h0000, "power down");
		rdc(8'h05, 16'h2000, "mask mirror");
		tprc_host_i.wr(8'h05, 16'hFF00);
		tprc_host_i.wr(8'h02, 16'h8000);
		rdc(8'h02, 16'h1440, "sw cfg");
		rdc(8'h05, 16'h0000, "sw mask");
		rdc(8'h00, 16'h0000, "sw volt");
		$display("test power finished");
		close_out;
	end
endmodule
bind tprc_core tprc_chk tprc_chk_i (
	.clk_sys(clk_sys),
	.rstn(rstn),
	.reg_addr(reg_addr),
	.reg_wr(reg_wr),
	.reg_wdata(reg_wdata),
	.reg_rd(reg_rd),
	.reg_rdata(reg_rdata),
	.conv_active(conv_active),
	.conv_restart(conv_restart),
	.transient_filter_en(transient_filter_en),
	.alert_n(alert_n)
);

// File: verif/tprc_host.sv
// Register host model: one-cycle strobes launched off the falling edge.
// Assumes the core takes strobes on the rising edge of clk_sys.
`timescale 1ns/1ps
module tprc_host (
	input logic clk_sys,
	input logic [15:0] reg_rdata,
	output logic [7:0] reg_addr,
	output logic reg_wr,
	output logic [15:0] reg_wdata,
	output logic reg_rd
);
	initial begin
		reg_addr = 8'h00;
		reg_wr = 1'h0;
		reg_wdata = 16'h0000;
		reg_rd = 1'h0;
	end
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(negedge clk_sys);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'h1;
		@(negedge clk_sys);
		reg_wr = 1'h0;
		// Stale data would hide a core that ignores the strobe
		reg_wdata = ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(negedge clk_sys);
		reg_addr = a;
		reg_rd = 1'h1;
		@(negedge clk_sys);
		reg_rd = 1'h0;
		d = reg_rdata;
	endtask
endmodule
